// *** hw/dcd_top.sv ***
`timescale 1ns/1ns
// What this block does
// - two 8-bit read/write data registers, one per channel, reset to zero
// - control register resets to 1F, enables clear, low bits set
// - control bits 4 to 0 are read-only and always read as one
// - control bit 7 enables channel-1 conversion and its output pin
// - control bit 6 enables channel-0 conversion and its output pin
// - joint enable clear: each channel follows its own enable bit
// - both enables, or joint plus one enable, run both channels
// - both enables clear stops both channels whatever joint says
// - enabled channel converts continuously; new data restarts conversion at once
// - output level is code over 256 times analog supply
// - result appears within the maximum conversion time after enable or change
// - last result held until data changes or enable clears
// - enable set makes pin an output; cleared releases its driver
// - in standby with conversion on, output held and converter powered
// - joint enable set keeps converters biased even with all starts clear
// - registers also decoded at the untranslated alternate address range
// - adc start bit is the converter start bit from the a/d control
module dcd_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [31:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic standby_i,
  input wire logic adc_start_bit_i,
  output logic [7:0] rdata_o,
  output logic [7:0] level0_o,
  output logic [7:0] level1_o,
  output logic analog_out_pin0_oe_o,
  output logic analog_out_pin1_oe_o,
  output logic [1:0] conv_busy_o,
  output logic analog_bias_o
);
  dcd_pkg::dcd_state_t st_ff;
  dcd_pkg::dcd_state_t nxt_st;
  logic [31:0] phys;
  logic hit0;
  logic hit1;
  logic hitc;
  logic [1:0] en;
  logic [1:0] dchg;
  logic [7:0] ctrl_rd;

  // ************************************
  // address decode
  // ************************************
  // alternate range folds onto the physical one
  always_comb begin
    phys = addr_i;
    if ((addr_i & dcd_pkg::ALT_MASK) == dcd_pkg::ALT_BASE) begin
      phys = addr_i & ~dcd_pkg::ALT_MASK;
    end
  end
  assign hit0 = (phys == dcd_pkg::DATA_CH0_ADDR);
  assign hit1 = (phys == dcd_pkg::DATA_CH1_ADDR);
  assign hitc = (phys == dcd_pkg::CONTROL_ADDR);

  // control read view, reserved bits forced to one
  assign ctrl_rd = {st_ff.oe1, st_ff.oe0, st_ff.joint, 5'h00} | dcd_pkg::CONTROL_RSVD;

  // ************************************
  // next state
  // ************************************
  always_comb begin
    nxt_st = st_ff;
    // register writes
    if (wr_i && hit0) begin
      nxt_st.data0 = wdata_i;
    end
    if (wr_i && hit1) begin
      nxt_st.data1 = wdata_i;
    end
    // low bits of the write are dropped
    if (wr_i && hitc) begin
      nxt_st.oe1 = wdata_i[dcd_pkg::OE1_BIT];
      nxt_st.oe0 = wdata_i[dcd_pkg::OE0_BIT];
      nxt_st.joint = wdata_i[dcd_pkg::JOINT_BIT];
    end
    // read data; unmapped addresses read zero
    nxt_st.rdata = 8'h00;
    if (rd_i && hit0) begin
      nxt_st.rdata = st_ff.data0;
    end else if (rd_i && hit1) begin
      nxt_st.rdata = st_ff.data1;
    end else if (rd_i && hitc) begin
      nxt_st.rdata = ctrl_rd;
    end
    // per-channel conversion state
    for (int i = 0; i < 2; i++) begin
      nxt_st.run[i] = en[i];
      // a fresh enable or data change restarts the settling window
      if (en[i] && (!st_ff.run[i] || dchg[i])) begin
        nxt_st.conv[i].busy = 1'b1;
        nxt_st.conv[i].cnt = 10'h000;
      end else if (!en[i]) begin
        nxt_st.conv[i].busy = 1'b0;
        nxt_st.conv[i].cnt = 10'h000;
      end else if (st_ff.conv[i].busy) begin
        nxt_st.conv[i].cnt = st_ff.conv[i].cnt + 10'h001;
        if (st_ff.conv[i].cnt == dcd_pkg::CONV_CYC - 10'h002) begin
          nxt_st.conv[i].busy = 1'b0;
        end
      end
    end
    // pin direction follows its own enable bit only
    nxt_st.pin_oe = {nxt_st.oe1, nxt_st.oe0};
    // level = code/256 of supply: code passed as-is to the analog stage
    // held in standby and while data unchanged
    if (en[0] && !standby_i) begin
      nxt_st.level0 = st_ff.data0;
    end
    if (en[1] && !standby_i) begin
      nxt_st.level1 = st_ff.data1;
    end
    // bias stays on with joint enable even if nothing runs
    nxt_st.bias = st_ff.joint | (|en) | adc_start_bit_i;
  end

  // channel enables from the control combination
  always_comb begin
    en = 2'h0;
    if (st_ff.oe0 && st_ff.oe1) begin
      en = 2'h3;
    end else if (st_ff.joint && (st_ff.oe0 || st_ff.oe1)) begin
      en = 2'h3;
    end else begin
      en = {st_ff.oe1, st_ff.oe0};
    end
  end

  // data change seen one cycle after the write
  always_comb begin
    dchg[0] = (st_ff.level0 != st_ff.data0);
    dchg[1] = (st_ff.level1 != st_ff.data1);
  end

  // ************************************
  // state register
  // ************************************
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.data0 <= dcd_pkg::DATA_RESET;
      st_ff.data1 <= dcd_pkg::DATA_RESET;
      // enables take the reset pattern; the reserved ones come from the read view
      st_ff.oe1 <= dcd_pkg::CONTROL_RESET[dcd_pkg::OE1_BIT];
      st_ff.oe0 <= dcd_pkg::CONTROL_RESET[dcd_pkg::OE0_BIT];
      st_ff.joint <= dcd_pkg::CONTROL_RESET[dcd_pkg::JOINT_BIT];
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = st_ff.rdata;
  assign level0_o = st_ff.level0;
  assign level1_o = st_ff.level1;
  assign analog_out_pin0_oe_o = st_ff.pin_oe[0];
  assign analog_out_pin1_oe_o = st_ff.pin_oe[1];
  assign conv_busy_o = {st_ff.conv[1].busy, st_ff.conv[0].busy};
  assign analog_bias_o = st_ff.bias;

  // ************************************
  // assertions
  // ************************************
  a_ctrl_reserved_ones: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && hitc) |=> rdata_o[4:0] == 5'h1F) else $error("reserved bits not one");
  a_ctrl_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hitc) ##1 (rd_i && hitc && !wr_i) |=> rdata_o[7:5] == $past(wdata_i[7:5], 2))
    else $error("control readback mismatch");
  a_data_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hit0) ##1 (rd_i && hit0 && !wr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("data0 readback mismatch");
  a_both_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!st_ff.oe0 && !st_ff.oe1) |=> conv_busy_o == 2'b00) else $error("converter ran with both off");
  a_joint_both: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_ff.joint && st_ff.oe0 && !st_ff.run[1]) |=> st_ff.run[1]) else $error("joint did not start ch1");
  a_indep_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!st_ff.joint && st_ff.oe0 && !st_ff.oe1) |=> !st_ff.run[1]) else $error("ch1 ran alone");
  a_pin_dir: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hitc) |=> analog_out_pin1_oe_o == $past(wdata_i[7]) &&
    analog_out_pin0_oe_o == $past(wdata_i[6])) else $error("pin direction wrong");
  a_conv_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv_busy_o[0] |-> st_ff.conv[0].cnt < dcd_pkg::CONV_CYC - 10'h001)
    else $error("conversion window too long");
  a_standby_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    standby_i |=> $stable(level0_o) && $stable(level1_o)) else $error("output moved in standby");
  a_joint_bias: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.joint |=> analog_bias_o) else $error("bias dropped with joint set");

  // ************************************
  // register contents
  // ************************************
  // both data registers come out of reset cleared
  a_reset_data: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(rst_i) |-> st_ff.data0 == dcd_pkg::DATA_RESET && st_ff.data1 == dcd_pkg::DATA_RESET)
    else $error("data not cleared by reset");
  // control shows its reset pattern on the first edge out of reset
  a_reset_ctrl: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(rst_i) |-> ctrl_rd == dcd_pkg::CONTROL_RESET)
    else $error("control not at reset pattern");
  // registers move only on a decoded write, so stray strobes cannot corrupt them
  a_data0_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_i && hit0) |=> $stable(st_ff.data0))
    else $error("data0 changed without write");
  a_data1_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_i && hit1) |=> $stable(st_ff.data1))
    else $error("data1 changed without write");
  a_ctrl_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(wr_i && hitc) |=> $stable(ctrl_rd))
    else $error("control changed without write");
  // read paths of channel 1 and of control
  a_read_data1: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && hit1) |=> rdata_o == $past(st_ff.data1))
    else $error("data1 read wrong");
  a_read_ctrl: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_i && hitc) |=> rdata_o == $past(ctrl_rd))
    else $error("control read wrong");
  // write then read on the next edge returns the new channel-1 code
  a_data1_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && hit1) ##1 (rd_i && hit1 && !wr_i) |=> rdata_o == $past(wdata_i, 2))
    else $error("data1 readback mismatch");
  // the untranslated window reaches the same control bits
  a_alt_ctrl: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_i && addr_i == (dcd_pkg::CONTROL_ADDR | dcd_pkg::ALT_BASE)) |=>
    ctrl_rd[7:5] == $past(wdata_i[7:5]))
    else $error("alternate control write lost");

  // ************************************
  // channel enables
  // ************************************
  // each own enable bit alone is enough to run its channel
  a_oe1_run: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.oe1 |=> st_ff.run[1])
    else $error("ch1 not running with its enable");
  a_oe0_run: assert property (@(posedge mclk_i) disable iff (rst_i)
    st_ff.oe0 |=> st_ff.run[0])
    else $error("ch0 not running with its enable");
  a_indep_ch0: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!st_ff.joint && !st_ff.oe0 && st_ff.oe1) |=> !st_ff.run[0])
    else $error("ch0 ran alone");
  // joint widening, the both-on case and the both-off case
  a_both_on: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_ff.oe0 && st_ff.oe1) |=> st_ff.run == 2'h3)
    else $error("both enables did not run both");
  a_joint_ch0: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_ff.joint && st_ff.oe1 && !st_ff.oe0) |=> st_ff.run[0])
    else $error("joint did not start ch0");
  a_both_off_run: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!st_ff.oe0 && !st_ff.oe1) |=> st_ff.run == 2'h0)
    else $error("channel ran with both off");

  // ************************************
  // conversion and output level
  // ************************************
  // a data change restarts the window at once, even mid-conversion
  a_restart_ch0: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[0] && dchg[0]) |=> conv_busy_o[0] && st_ff.conv[0].cnt == 10'h000)
    else $error("ch0 did not restart");
  a_restart_ch1: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[1] && dchg[1]) |=> conv_busy_o[1] && st_ff.conv[1].cnt == 10'h000)
    else $error("ch1 did not restart");
  a_enable_start: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[0] && !st_ff.run[0]) |=> conv_busy_o[0])
    else $error("ch0 enable did not start conversion");
  // level follows the code one edge later while running and awake
  a_level_track0: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[0] && !standby_i) |=> level0_o == $past(st_ff.data0))
    else $error("level0 does not follow data");
  a_level_track1: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[1] && !standby_i) |=> level1_o == $past(st_ff.data1))
    else $error("level1 does not follow data");
  // unchanged data keeps the last result on the pin
  a_level_hold0: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[0] && !dchg[0]) |=> $stable(level0_o))
    else $error("level0 moved without data change");
  a_level_hold1: assert property (@(posedge mclk_i) disable iff (rst_i)
    (en[1] && !dchg[1]) |=> $stable(level1_o))
    else $error("level1 moved without data change");
  // window never outlasts the conversion count and ends one cycle short of it
  a_conv_bound_ch1: assert property (@(posedge mclk_i) disable iff (rst_i)
    conv_busy_o[1] |-> st_ff.conv[1].cnt < dcd_pkg::CONV_CYC - 10'h001)
    else $error("ch1 conversion window too long");
  a_conv_end_ch0: assert property (@(posedge mclk_i) disable iff (rst_i)
    (conv_busy_o[0] && en[0] && !dchg[0] && st_ff.conv[0].cnt == dcd_pkg::CONV_CYC - 10'h002)
    |=> !conv_busy_o[0])
    else $error("ch0 conversion did not end");
  a_conv_end_ch1: assert property (@(posedge mclk_i) disable iff (rst_i)
    (conv_busy_o[1] && en[1] && !dchg[1] && st_ff.conv[1].cnt == dcd_pkg::CONV_CYC - 10'h002)
    |=> !conv_busy_o[1])
    else $error("ch1 conversion did not end");

  // ************************************
  // pins and power
  // ************************************
  // clearing the enable releases the driver in the same edge
  a_pin_release: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(st_ff.oe0) |-> !analog_out_pin0_oe_o)
    else $error("pin0 driver not released");
  a_standby_power: assert property (@(posedge mclk_i) disable iff (rst_i)
    (standby_i && |en) |=> analog_bias_o)
    else $error("converter unpowered in standby");
  a_bias_adc: assert property (@(posedge mclk_i) disable iff (rst_i)
    adc_start_bit_i |=> analog_bias_o)
    else $error("bias dropped with a/d start set");
  c_ch0_conv: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(conv_busy_o[0]));
  c_ch1_conv: cover property (@(posedge mclk_i) disable iff (rst_i) $fell(conv_busy_o[1]));
  c_joint_pair: cover property (@(posedge mclk_i) disable iff (rst_i) st_ff.joint && st_ff.oe1 && !st_ff.oe0);
  c_standby_run: cover property (@(posedge mclk_i) disable iff (rst_i) standby_i && st_ff.run[0]);
  c_alt_access: cover property (@(posedge mclk_i) disable iff (rst_i) wr_i && hitc && addr_i[31]);

endmodule // dcd_top

// *** hw/dcd_pkg.sv ***
package dcd_pkg;
  // ************************************
  // register map
  // ************************************
  localparam logic [31:0] DATA_CH0_ADDR = 32'h040000A0;
  localparam logic [31:0] DATA_CH1_ADDR = 32'h040000A2;
  localparam logic [31:0] CONTROL_ADDR = 32'h040000A4;
  localparam logic [31:0] ALT_BASE = 32'hA0000000;
  localparam logic [31:0] ALT_MASK = 32'hF0000000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h1F;
  localparam logic [7:0] CONTROL_RSVD = 8'h1F;
  localparam int OE1_BIT = 7;
  localparam int OE0_BIT = 6;
  localparam int JOINT_BIT = 5;
  // ************************************
  // timing
  // ************************************
  localparam int CONV_TIME_NS = 10000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam logic [9:0] CONV_CYC = 10'(CONV_CYCLES);

  typedef struct packed {
    logic [9:0] cnt;
    logic busy;
  } dcd_conv_t;

  typedef struct packed {
    logic [7:0] data0;
    logic [7:0] data1;
    logic oe0;
    logic oe1;
    logic joint;
    dcd_conv_t [1:0] conv;
    logic [1:0] run;
    logic [1:0] pin_oe;
    logic [7:0] level0;
    logic [7:0] level1;
    logic [7:0] rdata;
    logic bias;
  } dcd_state_t;
endpackage

// *** tb/testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [31:0] addr_i = 32'h00000000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic standby_i = 1'b0;
  logic adc_start_bit_i = 1'b0;
  logic [7:0] rdata_o, level0_o, level1_o;
  logic pin0_oe, pin1_oe, analog_bias_o;
  logic [1:0] conv_busy_o;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  logic [15:0] rnd = 16'h2F66;
  logic [7:0] v, c;
  logic [31:0] a0;

  // free-running 50 MHz clock
  always #10 mclk_i = ~mclk_i;

  dcd_top dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .standby_i(standby_i), .adc_start_bit_i(adc_start_bit_i),
    .rdata_o(rdata_o), .level0_o(level0_o), .level1_o(level1_o),
    .analog_out_pin0_oe_o(pin0_oe), .analog_out_pin1_oe_o(pin1_oe),
    .conv_busy_o(conv_busy_o), .analog_bias_o(analog_bias_o));

  // ************************************
  // helpers
  // ************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected run flags {ch1, ch0}: joint only widens a single enable to both
  function automatic logic [1:0] exp_run(input logic [7:0] cr);
    if (cr[7] & cr[6]) return 2'b11;
    if (cr[5] & (cr[7] | cr[6])) return 2'b11;
    return cr[7:6];
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // strobe held for exactly the one taking edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e, input string what);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, what);
  endtask
  // write then read on the very next edge, no idle cycle between
  task automatic wr_rd(input logic [31:0] a, input logic [7:0] d, input logic [7:0] e,
    input string what);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e, what);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog well beyond the ~5k cycles the tests need
  initial begin
    #(20 * 60000);
    mismatches++;
    tally_and_finish();
  end

  // ************************************
  // tests
  // ************************************
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(dcd_pkg::DATA_CH0_ADDR, 8'h00, "data0 reset");
    rd(dcd_pkg::DATA_CH1_ADDR, 8'h00, "data1 reset");
    rd(dcd_pkg::CONTROL_ADDR, 8'h1F, "ctrl reset");
    $display("test reset done");
    // every enable combination, random reserved bits and a/d start
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      c = {k[2:0], rnd[4:0]};
      wr(dcd_pkg::CONTROL_ADDR, 8'h00);
      repeat (505) @(posedge mclk_i);
      adc_start_bit_i <= rnd[5];
      wr(dcd_pkg::CONTROL_ADDR, c);
      repeat (3) @(posedge mclk_i);
      #1;
      chk({6'h00, conv_busy_o}, {6'h00, exp_run(c)}, "run");
      chk({6'h00, pin1_oe, pin0_oe}, {6'h00, c[7:6]}, "pin drive");
      chk({7'h00, analog_bias_o}, {7'h00, c[5] | c[7] | c[6] | rnd[5]}, "bias");
      rd(dcd_pkg::CONTROL_ADDR, {c[7:5], 5'h1F}, "ctrl read");
    end
    rnd = lfsr(rnd);
    wr_rd(32'hA40000A4, rnd[7:0], {rnd[7:5], 5'h1F}, "ctrl b2b");
    wr_rd(dcd_pkg::DATA_CH0_ADDR, rnd[15:8], rnd[15:8], "data0 b2b");
    wr_rd(32'hA40000A2, ~rnd[15:8], ~rnd[15:8], "data1 b2b");
    $display("test enables done");
    wr(dcd_pkg::CONTROL_ADDR, 8'hC0);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : rnd[7:0];
      a0 = k[0] ? (dcd_pkg::DATA_CH0_ADDR | 32'hA0000000) : dcd_pkg::DATA_CH0_ADDR;
      wr(a0, v);
      wr(dcd_pkg::DATA_CH1_ADDR, ~v);
      @(posedge mclk_i);
      #1;
      chk(level0_o, v, "level0");
      chk(level1_o, ~v, "level1");
      rd(a0, v, "data0 read");
    end
    // conversion window after the last data change
    n = 0;
    while (conv_busy_o !== 2'b00 && n < 600) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    #1;
    chk({7'h00, n > 480 && n < 510}, 8'h01, "conv time");
    chk(level0_o, v, "level held");
    $display("test data done");
    @(posedge mclk_i);
    standby_i <= 1'b1;
    wr(dcd_pkg::DATA_CH0_ADDR, 8'h5A);
    repeat (3) @(posedge mclk_i);
    #1;
    chk(level0_o, v, "standby hold");
    chk({7'h00, analog_bias_o}, 8'h01, "standby power");
    @(posedge mclk_i);
    standby_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(level0_o, 8'h5A, "after standby");
    rd(32'h040000A6, 8'h00, "unmapped");
    wr(dcd_pkg::CONTROL_ADDR, 8'h00);
    repeat (3) @(posedge mclk_i);
    #1;
    chk({6'h00, pin1_oe, pin0_oe}, 8'h00, "pins released");
    // software parks both enables before standby: converter draws no bias
    @(posedge mclk_i);
    adc_start_bit_i <= 1'b0;
    standby_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk({7'h00, analog_bias_o}, 8'h00, "standby low power");
    @(posedge mclk_i);
    standby_i <= 1'b0;
    $display("test standby done");
    // second reset in mid-run
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(dcd_pkg::DATA_CH0_ADDR, 8'h00, "data0 rereset");
    rd(dcd_pkg::CONTROL_ADDR, 8'h1F, "ctrl rereset");
    $display("test rereset done");
    tally_and_finish();
  end
endmodule // testbench
